// *** shared/nrbt_pkg.sv ***
// package for the nibble rotate / bit test datapath
// assumes one processor clock; memory answers reads in the cycle after a request
package nrbt_pkg;
	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [7:0] OP_PREFIX_ED = 8'hed;
	localparam logic [7:0] OP_RLD_DIGIT = 8'h6f;
	localparam logic [7:0] OP_RRD_DIGIT = 8'h67;
	localparam logic [7:0] OP_PREFIX_CB = 8'hcb;
	localparam logic [7:0] OP_PREFIX_DD = 8'hdd;
	localparam logic [1:0] BIT_GROUP = 2'h1;
	localparam logic [2:0] MEM_OPERAND = 3'h6;
	localparam logic [2:0] ACC_CODE = 3'h7;
	// ****************************************
	// flag positions and reset values
	// ****************************************
	localparam int FLAG_S = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_H = 4;
	localparam int FLAG_PV = 2;
	localparam int FLAG_N = 1;
	localparam int FLAG_C = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ACC_RESET = 8'h00;
	// ****************************************
	// machine cycle lengths in clock states
	// ****************************************
	localparam int ROT_MCYCLES = 5;
	localparam logic [2:0] ROT_TSTATES [5] = '{3'h4, 3'h4, 3'h3, 3'h4, 3'h3};
	localparam int BREG_MCYCLES = 2;
	localparam logic [2:0] BREG_TSTATES [5] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h0};
	localparam int BHL_MCYCLES = 3;
	localparam logic [2:0] BHL_TSTATES [5] = '{3'h4, 3'h4, 3'h4, 3'h0, 3'h0};
	localparam int BIX_MCYCLES = 5;
	localparam logic [2:0] BIX_TSTATES [5] = '{3'h4, 3'h4, 3'h3, 3'h5, 3'h4};
	// memory cycle index: rotate reads in m3, writes in m5; bit tests read in last
	localparam logic [2:0] ROT_READ_M = 3'h2;
	localparam logic [2:0] ROT_WRITE_M = 3'h4;

	typedef enum logic [2:0] {NRBT_NONE, NRBT_RLD, NRBT_RRD, NRBT_BREG, NRBT_BHL,
		NRBT_BIX} nrbt_op_t;

	typedef struct packed {
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] h;
		logic [7:0] l;
		logic [15:0] ix;
	} nrbt_regs_t;

	typedef struct packed {
		logic req;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} nrbt_mem_t;
endpackage : nrbt_pkg

// *** design/nrbt_unit.sv ***
// nibble rotate and single-bit test execution unit
// assumes the sequencer holds instr bytes stable while start_i pulses and
// that memory returns read data on mem_rdata_i the cycle after a read request
`timescale 1ns/1ps
module nrbt_unit (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [7:0] op0_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [7:0] op3_i,
	input wire nrbt_pkg::nrbt_regs_t regs_i,
	input wire logic [15:0] pointer_pair_i,
	input wire logic [7:0] acc_load_i,
	input wire logic [7:0] flags_load_i,
	input wire logic load_i,
	input wire logic [7:0] mem_rdata_i,
	output nrbt_pkg::nrbt_mem_t mem_o,
	output logic [7:0] acc_o,
	output logic [7:0] flags_o,
	output logic busy_o,
	output logic done_o,
	output logic illegal_o,
	output logic [2:0] mcycle_o,
	output logic [2:0] tstate_o
);
	import nrbt_pkg::*;

	// ****************************************
	// decode
	// ****************************************
	function automatic nrbt_op_t decode(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		decode = NRBT_NONE;
		if (a == OP_PREFIX_ED && b == OP_RLD_DIGIT) begin
			decode = NRBT_RLD;
		end else if (a == OP_PREFIX_ED && b == OP_RRD_DIGIT) begin
			decode = NRBT_RRD;
		end else if (a == OP_PREFIX_CB && b[7:6] == BIT_GROUP) begin
			if (b[2:0] == MEM_OPERAND) begin
				decode = NRBT_BHL;
			end else if (b[2:0] <= 3'h5 || b[2:0] == ACC_CODE) begin
				decode = NRBT_BREG;
			end
		end else if (a == OP_PREFIX_DD && b == OP_PREFIX_CB && c[7:6] == BIT_GROUP
			&& c[2:0] == MEM_OPERAND) begin
			decode = NRBT_BIX;
		end
	endfunction : decode

	function automatic logic [7:0] reg_sel(input nrbt_regs_t r, input logic [7:0] a,
		input logic [2:0] code);
		unique case (code)
			3'h0: reg_sel = r.b;
			3'h1: reg_sel = r.c;
			3'h2: reg_sel = r.d;
			3'h3: reg_sel = r.e;
			3'h4: reg_sel = r.h;
			3'h5: reg_sel = r.l;
			default: reg_sel = a;
		endcase
	endfunction : reg_sel

	function automatic logic is_rot(input nrbt_op_t o);
		is_rot = (o == NRBT_RLD || o == NRBT_RRD);
	endfunction : is_rot

	nrbt_op_t start_op;
	nrbt_op_t op;
	logic [7:0] sel_byte;
	logic [2:0] bit_idx;
	logic [7:0] mem_byte;
	logic [2:0] last_m;
	logic [2:0] t_len;
	logic last_state;
	logic [15:0] addr;
	logic [7:0] operand;
	logic [7:0] next_acc;
	logic [7:0] next_mem;
	logic [7:0] wr_byte;

	// indexed form carries the bit byte last, after the displacement;
	// op2_i is only the displacement there and never decides the form
	assign start_op = decode(op0_i, op1_i, op3_i);

	// ****************************************
	// sequencing
	// ****************************************
	always_comb begin
		unique case (op)
			NRBT_RLD, NRBT_RRD: begin
				t_len = ROT_TSTATES[mcycle_o];
				last_m = 3'(ROT_MCYCLES - 1);
			end
			NRBT_BREG: begin
				t_len = BREG_TSTATES[mcycle_o];
				last_m = 3'(BREG_MCYCLES - 1);
			end
			NRBT_BHL: begin
				t_len = BHL_TSTATES[mcycle_o];
				last_m = 3'(BHL_MCYCLES - 1);
			end
			NRBT_BIX: begin
				t_len = BIX_TSTATES[mcycle_o];
				last_m = 3'(BIX_MCYCLES - 1);
			end
			default: begin
				t_len = 3'h1;
				last_m = 3'h0;
			end
		endcase
	end

	assign last_state = busy_o && (tstate_o == t_len - 3'h1);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			busy_o <= 1'b0;
			op <= NRBT_NONE;
			mcycle_o <= 3'h0;
			tstate_o <= 3'h0;
		end else if (!busy_o) begin
			if (start_i && start_op != NRBT_NONE) begin
				busy_o <= 1'b1;
				op <= start_op;
				mcycle_o <= 3'h0;
				tstate_o <= 3'h0;
			end
		end else if (last_state) begin
			tstate_o <= 3'h0;
			if (mcycle_o == last_m) begin
				busy_o <= 1'b0;
				op <= NRBT_NONE;
				mcycle_o <= 3'h0;
			end else begin
				mcycle_o <= mcycle_o + 3'h1;
			end
		end else begin
			tstate_o <= tstate_o + 3'h1;
		end
	end

	// operands latched at start so the sequencer may move on
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			sel_byte <= 8'h00;
			bit_idx <= 3'h0;
			addr <= 16'h0000;
		end else if (!busy_o && start_i) begin
			sel_byte <= reg_sel(regs_i, acc_o, op1_i[2:0]);
			bit_idx <= (start_op == NRBT_BIX) ? op3_i[5:3] : op1_i[5:3];
			addr <= (start_op == NRBT_BIX) ? regs_i.ix + {{8{op2_i[7]}}, op2_i}
				: pointer_pair_i;
		end
	end

	// ****************************************
	// memory cycles
	// ****************************************
	// rotates read at start of m3 and write at start of m5; memory bit tests read at start of their last m-cycle
	always_comb begin
		mem_o.addr = addr;
		mem_o.wdata = wr_byte;
		mem_o.req = 1'b0;
		mem_o.wr = 1'b0;
		if (busy_o && tstate_o == 3'h0) begin
			if (is_rot(op) && mcycle_o == ROT_READ_M) begin
				mem_o.req = 1'b1;
			end else if (is_rot(op) && mcycle_o == ROT_WRITE_M) begin
				mem_o.req = 1'b1;
				mem_o.wr = 1'b1;
			end else if ((op == NRBT_BHL || op == NRBT_BIX) && mcycle_o == last_m) begin
				// bit tests only ever read memory
				mem_o.req = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			mem_byte <= 8'h00;
		end else if (busy_o && tstate_o == 3'h1 && op != NRBT_BREG
			&& (mcycle_o == ROT_READ_M || mcycle_o == last_m) && op != NRBT_NONE) begin
			// read data arrives one cycle after the request
			if (!(is_rot(op) && mcycle_o == ROT_WRITE_M)) begin
				mem_byte <= mem_rdata_i;
			end
		end
	end

	// ****************************************
	// write data
	// ****************************************
	// new byte held in a flop before the write slot, so the data bus stays
	// steady while the write strobe stands; assumes acc and the read byte
	// do not move between the end of m4 and the write
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			wr_byte <= 8'h00;
		end else if (is_rot(op) && busy_o && last_state
			&& mcycle_o == ROT_WRITE_M - 3'h1) begin
			wr_byte <= next_mem;
		end
	end

	// ****************************************
	// nibble datapath
	// ****************************************
	always_comb begin
		next_acc = acc_o;
		next_mem = mem_byte;
		if (op == NRBT_RLD) begin
			// left digit move, upper acc kept
			next_acc = {acc_o[7:4], mem_byte[7:4]};
			next_mem = {mem_byte[3:0], acc_o[3:0]};
		end else if (op == NRBT_RRD) begin
			// right digit move, upper acc kept
			next_acc = {acc_o[7:4], mem_byte[3:0]};
			next_mem = {acc_o[3:0], mem_byte[7:4]};
		end
	end

	// memory operand is the byte caught in the answer cycle; the data bus
	// is not held by memory after that cycle
	assign operand = (op == NRBT_BREG) ? sel_byte : mem_byte;

	// ****************************************
	// accumulator, flags, completion
	// ****************************************
	// acc updates at the last state of m5, after the data bus already holds next_mem
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			acc_o <= ACC_RESET;
		end else if (load_i && !busy_o) begin
			acc_o <= acc_load_i;
		end else if (busy_o && last_state && mcycle_o == last_m
			&& is_rot(op)) begin
			acc_o <= next_acc;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			flags_o <= FLAGS_RESET;
		end else if (load_i && !busy_o) begin
			flags_o <= flags_load_i;
		end else if (busy_o && last_state && mcycle_o == last_m) begin
			if (is_rot(op)) begin
				flags_o[FLAG_S] <= next_acc[7];
				flags_o[FLAG_Z] <= (next_acc == 8'h00);
				flags_o[FLAG_PV] <= ~^next_acc;
				// h and n cleared, carry kept
				flags_o[FLAG_H] <= 1'b0;
				flags_o[FLAG_N] <= 1'b0;
			end else begin
				flags_o[FLAG_Z] <= ~operand[bit_idx];
				// h set, n cleared; s and pv left as they were
				flags_o[FLAG_H] <= 1'b1;
				flags_o[FLAG_N] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			done_o <= 1'b0;
			illegal_o <= 1'b0;
		end else begin
			done_o <= busy_o && last_state && mcycle_o == last_m;
			illegal_o <= !busy_o && start_i && start_op == NRBT_NONE;
		end
	end
endmodule : nrbt_unit

// *** sim/nrbt_chk.sv ***
// checker on the nrbt_unit ports
// bound to every nrbt_unit instance
`timescale 1ns/1ps
module nrbt_chk import nrbt_pkg::*; (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [7:0] op0_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op3_i,
	input wire nrbt_pkg::nrbt_mem_t mem_o,
	input wire logic [7:0] acc_o,
	input wire logic [7:0] flags_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic [2:0] mcycle_o,
	input wire logic [2:0] tstate_o
);
	// ****
	// assertions
	// ****
	logic rot;
	wire go = start_i && !busy_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// last taken op kind, judges flags at done
	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			rot <= 1'h0;
		else if (go)
			rot <= (op0_i == OP_PREFIX_ED);
	end
	a_rot_length: assert property (go && op0_i == OP_PREFIX_ED &&
		(op1_i == OP_RLD_DIGIT || op1_i == OP_RRD_DIGIT) |-> ##1 busy_o [*8] ##11 done_o)
		else $error("rotate length wrong");
	a_reg_length: assert property (go && op0_i == OP_PREFIX_CB &&
		op1_i[7:6] == BIT_GROUP && op1_i[2:0] != MEM_OPERAND |-> ##9 done_o)
		else $error("register test length wrong");
	a_ptr_length: assert property (go && op0_i == OP_PREFIX_CB &&
		op1_i[7:6] == BIT_GROUP && op1_i[2:0] == MEM_OPERAND |-> ##13 done_o)
		else $error("pointer test length wrong");
	a_idx_length: assert property (go && op0_i == OP_PREFIX_DD &&
		op1_i == OP_PREFIX_CB && op3_i[7:6] == BIT_GROUP && op3_i[2:0] == MEM_OPERAND
		|-> ##21 done_o) else $error("indexed test length wrong");
	a_write_slot: assert property (mem_o.req && mem_o.wr |-> rot &&
		mcycle_o == ROT_WRITE_M && tstate_o == 3'h0) else $error("write out of slot");
	a_read_slot: assert property (mem_o.req && !mem_o.wr && rot |->
		mcycle_o == ROT_READ_M && tstate_o == 3'h0) else $error("read out of slot");
	a_rot_flags: assert property (done_o && rot |-> flags_o[FLAG_S] == acc_o[7] &&
		flags_o[FLAG_Z] == (acc_o == 8'h00) && flags_o[FLAG_PV] == ~^acc_o &&
		!flags_o[FLAG_H] && !flags_o[FLAG_N]) else $error("rotate flags wrong");
	a_bit_flags: assert property (done_o && !rot |-> flags_o[FLAG_H] &&
		!flags_o[FLAG_N] && acc_o == $past(acc_o, 3)) else $error("bit test flags wrong");
	a_carry_kept: assert property (done_o |->
		flags_o[FLAG_C] == $past(flags_o[FLAG_C], 3)) else $error("carry changed");
	a_acc_upper: assert property (done_o && rot |->
		acc_o[7:4] == $past(acc_o[7:4], 3)) else $error("acc upper changed");
endmodule : nrbt_chk
bind nrbt_unit nrbt_chk u_chk (.mclk_i, .resetn_i, .start_i, .op0_i, .op1_i, .op3_i,
	.mem_o, .acc_o, .flags_o, .busy_o, .done_o, .mcycle_o, .tstate_o);

// *** sim/nrbt_mem.sv ***
// memory partner behind mem_o
// answers a read one cycle after the request, no wait
`timescale 1ns/1ps
module nrbt_mem import nrbt_pkg::*; (
	input wire logic mclk_i,
	input wire nrbt_pkg::nrbt_mem_t mem_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [logic [15:0]];
	logic [7:0] held = 8'h00;
	int writes = 0;
	initial rdata_o = 8'h00;
	always @(posedge mclk_i) begin
		if (mem_i.req && mem_i.wr) begin
			mem[mem_i.addr] = mem_i.wdata;
			writes++;
		end
		// released bus shows the inverse of the last answer, so a late
		// sample of the data bus is caught
		if (mem_i.req && !mem_i.wr) begin
			rdata_o <= mem[mem_i.addr];
			held = mem[mem_i.addr];
		end else begin
			rdata_o <= ~held;
		end
	end
endmodule : nrbt_mem

// *** sim/nrbt_unit_tb.sv ***
// bench for nrbt_unit
// inputs change on falling edges; nrbt_mem serves memory
`timescale 1ns/1ps
module nrbt_unit_tb;
	import nrbt_pkg::*;
	// ****
	// harness
	// ****
	logic mclk_i = 1'h0, resetn_i = 1'h0, start_i = 1'h0, load_i = 1'h0;
	logic [7:0] op0_i = 8'h00, op1_i = 8'h00, op2_i = 8'h00, op3_i = 8'h00;
	logic [7:0] acc_load_i = 8'h00, flags_load_i = 8'h00, mem_rdata_i;
	logic [15:0] pointer_pair_i = 16'h5000;
	logic [7:0] v [8] = '{8'ha5, 8'h5a, 8'h0f, 8'hf0, 8'h3c, 8'hc3, 8'h00, 8'h96};
	nrbt_regs_t regs_i;
	nrbt_mem_t mem_o;
	logic [7:0] acc_o, flags_o;
	logic busy_o, done_o, illegal_o;
	logic [2:0] mcycle_o, tstate_o;
	int fail_count = 0, checks = 0, cyc = 0;
	nrbt_unit u_nrbt_unit (.mclk_i, .resetn_i, .start_i, .op0_i, .op1_i, .op2_i, .op3_i,
		.regs_i, .pointer_pair_i, .acc_load_i, .flags_load_i, .load_i, .mem_rdata_i,
		.mem_o, .acc_o, .flags_o, .busy_o, .done_o, .illegal_o, .mcycle_o, .tstate_o);
	nrbt_mem u_nrbt_mem (.mclk_i, .mem_i(mem_o), .rdata_o(mem_rdata_i));
	always #2 mclk_i = ~mclk_i;
	// limit far above the roughly 1150 cycles needed
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic cmp(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic ld(input logic [7:0] a, f);
		@(negedge mclk_i);
		acc_load_i = a;
		flags_load_i = f;
		load_i = 1'h1;
		@(negedge mclk_i);
		load_i = 1'h0;
	endtask : ld
	task automatic run(input logic [7:0] o0, o1, o2, o3, input int n);
		int k;
		@(negedge mclk_i);
		{op0_i, op1_i, op2_i, op3_i} = {o0, o1, o2, o3};
		start_i = 1'h1;
		@(negedge mclk_i);
		start_i = 1'h0;
		k = 1;
		while (done_o !== 1'h1 && k < 40) begin
			@(negedge mclk_i);
			k++;
		end
		cmp(8'(k), 8'(n));
	endtask : run
	// ****
	// scenarios
	// ****
	task automatic t_rotate();
		logic [7:0] t [4][5];
		logic [7:0] ea, ef;
		t = '{'{OP_RLD_DIGIT, 8'h7a, 8'h31, 8'h73, 8'h1a},
			'{OP_RRD_DIGIT, 8'h84, 8'h20, 8'h80, 8'h42},
			'{OP_RRD_DIGIT, 8'h00, 8'h50, 8'h00, 8'h05},
			'{OP_RLD_DIGIT, 8'hf5, 8'hc9, 8'hfc, 8'h95}};
		for (int i = 0; i < 4; i++) begin
			ef = i[0] ? 8'h13 : 8'h00;
			ld(t[i][1], ef);
			u_nrbt_mem.mem[pointer_pair_i] = t[i][2];
			run(OP_PREFIX_ED, t[i][0], 8'h00, 8'h00, 19);
			ea = t[i][3];
			cmp(acc_o, ea);
			cmp(u_nrbt_mem.mem[pointer_pair_i], t[i][4]);
			cmp(flags_o & 8'hd7, {ea[7], ea == 8'h00, 3'h0, ~^ea, 1'h0, ef[0]});
		end
	endtask : t_rotate
	task automatic t_bit_reg();
		ld(v[7], 8'h01);
		for (int r = 0; r < 8; r++) begin
			for (int b = 0; b < 8 && r != 6; b++) begin
				run(OP_PREFIX_CB, {BIT_GROUP, b[2:0], r[2:0]}, 8'h00, 8'h00, 9);
				cmp(flags_o & 8'h53, {1'h0, ~v[r][b], 6'h11});
				cmp(acc_o, v[7]);
			end
		end
	endtask : t_bit_reg
	task automatic t_bit_mem();
		logic [7:0] p [3] = '{8'ha6, 8'h59, 8'hc1};
		logic [7:0] d [3] = '{8'h00, 8'h04, 8'hfc};
		int w;
		u_nrbt_mem.mem[pointer_pair_i] = p[0];
		u_nrbt_mem.mem[16'h2004] = p[1];
		u_nrbt_mem.mem[16'h1ffc] = p[2];
		ld(8'h3e, 8'h02);
		w = u_nrbt_mem.writes;
		for (int f = 0; f < 3; f++) begin
			for (int b = 0; b < 8; b++) begin
				if (f == 0)
					run(OP_PREFIX_CB, {BIT_GROUP, b[2:0], MEM_OPERAND}, 8'h00, 8'h00, 13);
				else
					run(OP_PREFIX_DD, OP_PREFIX_CB, d[f], {BIT_GROUP, b[2:0], MEM_OPERAND}, 21);
				cmp(flags_o & 8'h53, {1'h0, ~p[f][b], 6'h10});
			end
		end
		cmp(8'(u_nrbt_mem.writes - w), 8'h00);
	endtask : t_bit_mem
	task automatic t_refuse();
		@(negedge mclk_i);
		{op0_i, op1_i} = {OP_PREFIX_ED, 8'h00};
		start_i = 1'h1;
		@(negedge mclk_i);
		start_i = 1'h0;
		cmp({6'h00, busy_o, illegal_o}, 8'h01);
		fork
			run(OP_PREFIX_ED, OP_RLD_DIGIT, 8'h00, 8'h00, 19);
			begin
				repeat (4) @(negedge mclk_i);
				{op0_i, op1_i} = {OP_PREFIX_CB, 8'h47};
				start_i = 1'h1;
				@(negedge mclk_i);
				start_i = 1'h0;
			end
		join
	endtask : t_refuse
	initial begin
		regs_i = {v[0], v[1], v[2], v[3], v[4], v[5], 16'h2000};
		repeat (12) @(negedge mclk_i);
		resetn_i = 1'h1;
		t_rotate();
		t_bit_reg();
		t_bit_mem();
		t_refuse();
		end_sim();
	end
endmodule : nrbt_unit_tb
